// File: testbench/wwd_mcu.sv
/*
 * Supervised controller model: trigger pulses and the mode pin.
 * Assumes the resolved reset wire, low while a reset is driven.
 */
`timescale 1ns/100ps
`default_nettype none
module wwd_mcu (
    input  wire logic i_clk,
    input  wire logic i_reset_n,
    output var  logic o_trig,
    output var  logic o_mode
);
    // ==========================================
    // mode pin, floats high while held in reset
    bit auto_low = 1'b1;
    initial begin
        o_trig = 1'b0;
        o_mode = 1'b1;
    end
    always @(negedge i_reset_n) o_mode <= 1'b1;
    always @(posedge i_reset_n) begin
        repeat (8) @(posedge i_clk);
        if (auto_low) o_mode <= 1'b0;
    end
    // ==========================================
    // trigger pulses, edge aligned
    task automatic pulse(input int gap, input int width);
        repeat (gap) @(posedge i_clk);
        o_trig <= 1'b1;
        repeat (width) @(posedge i_clk);
        o_trig <= 1'b0;
    endtask : pulse
    task automatic set_mode(input logic m);
        @(posedge i_clk);
        o_mode <= m;
    endtask : set_mode
endmodule : wwd_mcu
`default_nettype wire

// File: testbench/wwd_top_bench.sv
/*
 * Self-checking bench: watchdog core facing a controller model.
 * Assumes short interval parameters and a pulled-up reset wire.
 */
`timescale 1ns/100ps
`default_nettype none
module wwd_top_bench;
    import wwd_pkg::*;
    // ==========================================
    // shortened intervals, oscillator cycles
    localparam logic [16:0] T0 = 17'h00014, T1 = 17'h0003C, T2 = 17'h0001E;
    localparam logic [16:0] T6 = 17'h0000A, T4L = 17'h0012C, T5L = 17'h000C8;
    logic       I_CLK  = 1'b0;
    logic       I_SRST = 1'b1;
    logic       ts     = 1'b0;
    logic [5:0] wake   = 6'h00;
    wire logic  trig, mode, rst_n, oe, rout, ena;
    int         mismatches = 0, total_checks = 0, rst_count = 0;
    int         hi_len = 0, last_len = 0, n;
    assign rst_n = oe ? rout : 1'b1;
    wwd_top #(.P_T0(T0), .P_T1(T1), .P_T2(T2), .P_T3(T2), .P_T6(T6),
              .P_T4_LO(T4L), .P_T5_LO(T5L)) i_wwd_top (
        .I_CLK(I_CLK), .I_SRST(I_SRST), .I_TRIG(trig), .I_MODE(mode),
        .I_WAKE(wake), .I_LONG_WINDOW_LENGTH_SELECT(ts),
        .I_RESET_IN(rst_n), .O_RESET_OUT(rout), .O_RESET_OE(oe),
        .O_PERIPHERAL_ENABLE_OUT(ena));
    wwd_mcu i_wwd_mcu (.i_clk(I_CLK), .i_reset_n(rst_n), .o_trig(trig),
                       .o_mode(mode));
    initial begin
        forever #2.5 I_CLK = ~I_CLK;
    end
    // ==========================================
    // reset pulse counting and length
    always @(posedge oe) rst_count++;
    always @(posedge I_CLK) begin
        if (I_SRST) hi_len = 0;
        else if (oe === 1'b1) hi_len++;
        else if (hi_len != 0) begin
            last_len = hi_len;
            hi_len = 0;
        end
    end
    // ==========================================
    // helpers
    task automatic cyc(input int k);
        repeat (k) @(negedge I_CLK);
    endtask : cyc
    task automatic check(input logic ok, input string what);
        total_checks++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("unexpected at %0t: %s", $time, what);
        end
    endtask : check
    // extra cycles let the pulse length land
    task automatic wait_low(input bit rise);
        for (int i = 0; rise && i < 3000 && oe !== 1'b1; i++) cyc(1);
        for (int i = 0; i < 3000 && oe !== 1'b0; i++) cyc(1);
        cyc(2);
    endtask : wait_low
    task automatic report_and_stop();
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : report_and_stop
    // gap 50 lands mid window whether mode fell late or early
    task automatic three_good();
        i_wwd_mcu.pulse(50, 10);
        i_wwd_mcu.pulse(30, 10);
        check(ena === 1'b0, "enable after two");
        i_wwd_mcu.pulse(30, 10);
        cyc(8);
        check(ena === 1'b1, "enable after three");
    endtask : three_good
    // ==========================================
    // scenarios
    task automatic t_por();
        wait_low(1'b0);
        check(last_len >= T0 && last_len <= T0 + 1, "power-up");
        for (int r = 0; r < 2; r++) begin
            n = rst_count;
            cyc(T1 - 5);
            check(rst_count == n, "early time-out");
            cyc(10);
            check(rst_count == n + 1, "time-out");
            if (r == 1) i_wwd_mcu.auto_low = 1'b1;
            wait_low(1'b0);
            check(last_len == T6, "pulse length");
        end
    endtask : t_por
    task automatic t_trig();
        three_good();
        n = rst_count;
        i_wwd_mcu.pulse(5, 10);
        cyc(5);
        check(ena === 1'b0, "enable after bad trigger");
        check(rst_count == n + 1, "trigger in disable");
        wait_low(1'b0);
        three_good();
        cyc(40);
        check(rst_count == n + 1, "reset in window");
        cyc(20);
        check(rst_count == n + 2 && ena === 1'b0, "missed window");
        wait_low(1'b0);
    endtask : t_trig
    task automatic t_len();
        n = rst_count;
        i_wwd_mcu.pulse(50, 40);
        cyc(15);
        check(rst_count == n, "40-cycle trigger");
        wait_low(1'b1);
        i_wwd_mcu.pulse(50, 60);
        check(rst_count == n + 2, "trigger too long");
        wait_low(1'b0);
    endtask : t_len
    task automatic t_long(input logic sel);
        int t4;
        int t5;
        t4 = sel ? WWD_T4_HI : T4L;
        t5 = sel ? WWD_T5_HI : T5L;
        three_good();
        @(posedge I_CLK);
        ts <= sel;
        i_wwd_mcu.set_mode(1'b1);
        cyc(10);
        check(ena === 1'b0, "enable in long mode");
        n = rst_count;
        i_wwd_mcu.pulse(t4 + t5 / 2 - 10, 10);
        cyc(5);
        check(rst_count == n, "long trigger");
        i_wwd_mcu.set_mode(1'b0);
        cyc(10);
        check(ena === 1'b1, "back to short");
        wait_low(1'b1);
    endtask : t_long
    // last pass takes bit 0 back down, a falling edge
    task automatic t_wake();
        @(posedge I_CLK);
        ts <= 1'b1;
        for (int k = 0; k < 7; k++) begin
            cyc(20);
            i_wwd_mcu.set_mode(1'b1);
            cyc(10);
            n = rst_count;
            @(posedge I_CLK);
            wake[k % 6] <= ~wake[k % 6];
            cyc(118);
            check(rst_count == n + 1 && last_len == T6, "wake");
            wait_low(1'b0);
        end
    endtask : t_wake
    initial begin
        i_wwd_mcu.auto_low = 1'b0;
        cyc(3);
        check(oe === 1'b1 && ena === 1'b0
              && rout === 1'b0, "reset state");
        @(posedge I_CLK);
        I_SRST <= 1'b0;
        t_por();
        t_trig();
        t_len();
        t_long(1'b0);
        t_long(1'b1);
        t_wake();
        report_and_stop();
    end
    initial begin
        #100000;
        mismatches++;
        report_and_stop();
    end
endmodule : wwd_top_bench
`default_nettype wire

// File: verilog/wwd_pkg.sv
/*
 * Constants for the dual-mode window watchdog: interval lengths in
 * oscillator cycles, debounce lengths, input bit positions, states.
 * Assumes the single clock of the block is the rc_clock_source.
 */
// How it works
// [R1] supply-monitor reset puts all logic in a known state, reset output on
// [R2] reset output stays asserted for t0 cycles after supply ramp-up
// [R3] controller drives mode low within t1 after power-up reset ends
// [R4] no mode low within t1: reset pulse of t6, then t1 restarts
// [R5] every reset pulse is followed by a fresh t1 switch-over phase
// [R6] after switch-over, short mode accepts triggers only in t3 after t2
// [R7] trigger held active too long causes a reset pulse
// [R8] trigger inside the disable interval causes a reset pulse
// [R9] enable window ending without trigger causes a reset pulse
// [R10] trigger rising edge in enable window restarts cycle with t2
// [R11] peripheral enable asserts after three consecutive correct triggers
// [R12] wrong trigger drops enable at once; three new correct ones needed
// [R13] mode high switches short-window mode to long-window mode
// [R14] long mode uses t4 then t5 with the same trigger checks
// [R15] peripheral enable held inactive during long-window mode
// [R16] wake-up in long mode: reset pulse t6, then switch-over phase
// [R17] wake-up inputs debounced; either edge in long mode is a wake-up
// [R18] time-select input picks one of two long interval pairs
// [R19] mode low during long mode returns to short-window mode
// [R20] all intervals are counts of oscillator clock cycles
// [R21] trigger high longer than 45 cycles is too long, causes reset
// [R22] time-select low: t4 is 71970 cycles, t5 is 30002 cycles
// [R23] time-select high: t4 is 1200 cycles, t5 is 400 cycles
// [R24] t0, t1, t2, t3, t6 are parameters in oscillator cycles
// [R25] trigger and mode synchronised and debounced before use
// [R26] events ignored during reset pulse; enable off until three triggers
package wwd_pkg;

    // ==========================================================
    // interval lengths, oscillator cycles
    localparam int             WWD_TW     = 17;
    localparam logic [16:0]    WWD_T0     = 17'h000C9;
    localparam logic [16:0]    WWD_T1     = 17'h00458;
    localparam logic [16:0]    WWD_T2     = 17'h00082;
    localparam logic [16:0]    WWD_T3     = 17'h0007C;
    localparam logic [16:0]    WWD_T4_LO  = 17'h11922;
    localparam logic [16:0]    WWD_T5_LO  = 17'h07532;
    localparam logic [16:0]    WWD_T4_HI  = 17'h004B0;
    localparam logic [16:0]    WWD_T5_HI  = 17'h00190;
    localparam logic [16:0]    WWD_T6     = 17'h00028;
    localparam logic [5:0]     WWD_TRIG_MAX = 6'h2D;

    // ==========================================================
    // debounce, stable cycles needed
    localparam logic [6:0]     WWD_DEB_TM   = 7'h03;
    localparam logic [6:0]     WWD_DEB_WAKE = 7'h60;
    // mode idles high by its pull-up, others low
    localparam logic [7:0]     WWD_DEB_INIT = 8'h80;

    // ==========================================================
    // input bit positions in the synchroniser vector
    localparam int             WWD_NWAKE  = 6;
    localparam int             WWD_B_TRIG = 6;
    localparam int             WWD_B_MODE = 7;
    localparam int             WWD_B_TS   = 8;

    typedef enum logic [6:0] {
        ST_POR  = 7'h01,
        ST_SWCH = 7'h02,
        ST_RST  = 7'h04,
        ST_SDIS = 7'h08,
        ST_SEN  = 7'h10,
        ST_LDIS = 7'h20,
        ST_LEN  = 7'h40
    } wwd_state_t;

endpackage : wwd_pkg

// File: verilog/wwd_top.sv
/*
 * Dual-mode window watchdog core: switch-over phase, short and long
 * trigger windows, wake-up inputs, open-drain reset and peripheral enable.
 * Assumes I_CLK is the oscillator clock and I_SRST the supply monitor.
 */
`timescale 1ns/100ps
`default_nettype none
module wwd_top #(
    parameter logic [16:0] P_T0    = wwd_pkg::WWD_T0,
    parameter logic [16:0] P_T1    = wwd_pkg::WWD_T1,
    parameter logic [16:0] P_T2    = wwd_pkg::WWD_T2,
    parameter logic [16:0] P_T3    = wwd_pkg::WWD_T3,
    parameter logic [16:0] P_T6    = wwd_pkg::WWD_T6,
    parameter logic [16:0] P_T4_LO = wwd_pkg::WWD_T4_LO,
    parameter logic [16:0] P_T5_LO = wwd_pkg::WWD_T5_LO
) (
    input  wire logic       I_CLK,
    input  wire logic       I_SRST,
    input  wire logic       I_TRIG,
    input  wire logic       I_MODE,
    input  wire logic [5:0] I_WAKE,
    input  wire logic       I_LONG_WINDOW_LENGTH_SELECT,
    input  wire logic       I_RESET_IN,
    output var  logic       O_RESET_OUT,
    output var  logic       O_RESET_OE,
    output var  logic       O_PERIPHERAL_ENABLE_OUT
);
    import wwd_pkg::*;

    // ==========================================================
    // synchronisers and debouncers
    logic [8:0]  sync1_reg;
    logic [8:0]  sync2_reg;
    logic [7:0]  deb_reg;
    logic [5:0]  wake_q_reg;
    logic        trig_q_reg;

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            sync1_reg <= {1'b0, WWD_DEB_INIT};
            sync2_reg <= {1'b0, WWD_DEB_INIT};
        end else begin
            sync1_reg <= {I_LONG_WINDOW_LENGTH_SELECT, I_MODE, I_TRIG, I_WAKE};
            sync2_reg <= sync1_reg; // R25
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_deb
            localparam logic [6:0] LEN =
                (gi < WWD_NWAKE) ? WWD_DEB_WAKE : WWD_DEB_TM;
            logic [6:0] cnt_reg;
            // a level must hold LEN cycles before it is believed
            always_ff @(posedge I_CLK) begin
                if (I_SRST) begin
                    cnt_reg    <= 7'h00;
                    deb_reg[gi] <= WWD_DEB_INIT[gi];
                end else if (sync2_reg[gi] == deb_reg[gi]) begin
                    cnt_reg <= 7'h00;
                end else if (cnt_reg == LEN - 7'h01) begin
                    cnt_reg    <= 7'h00;
                    deb_reg[gi] <= sync2_reg[gi]; // R17 R25
                end else begin
                    cnt_reg <= cnt_reg + 7'h01;
                end
            end
        end
    endgenerate

    logic       trig_deb;
    logic       mode_deb;
    logic       ts_lvl;
    logic       trig_rise;
    logic       wake_evt;
    assign trig_deb  = deb_reg[WWD_B_TRIG];
    assign mode_deb  = deb_reg[WWD_B_MODE];
    assign ts_lvl    = sync2_reg[WWD_B_TS];
    assign trig_rise = trig_deb & ~trig_q_reg;
    assign wake_evt  = |(deb_reg[5:0] ^ wake_q_reg); // R17

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            trig_q_reg <= 1'b0;
            wake_q_reg <= 6'h00;
        end else begin
            trig_q_reg <= trig_deb;
            wake_q_reg <= deb_reg[5:0];
        end
    end

    // ==========================================================
    // trigger length check
    logic [5:0] trig_cnt_reg;
    logic       trig_long;
    assign trig_long = trig_deb && (trig_cnt_reg == WWD_TRIG_MAX); // R21

    always_ff @(posedge I_CLK) begin
        if (I_SRST || !trig_deb)
            trig_cnt_reg <= 6'h00;
        else if (trig_cnt_reg != WWD_TRIG_MAX)
            trig_cnt_reg <= trig_cnt_reg + 6'h01; // R7
    end

    // ==========================================================
    // interval timer
    wwd_state_t  state_reg;
    wwd_state_t  state_next;
    logic [16:0] tmr_reg;
    logic [16:0] lim;
    logic        tmr_done;

    always_comb begin
        case (state_reg)
            ST_POR:  lim = P_T0; // R2 R24
            ST_SWCH: lim = P_T1; // R24
            ST_RST:  lim = P_T6; // R24
            ST_SDIS: lim = P_T2; // R6
            ST_SEN:  lim = P_T3; // R6
            ST_LDIS: lim = ts_lvl ? WWD_T4_HI : P_T4_LO; // R18 R22 R23
            ST_LEN:  lim = ts_lvl ? WWD_T5_HI : P_T5_LO; // R18 R22 R23
            default: lim = P_T0;
        endcase
    end
    assign tmr_done = (tmr_reg == lim - 17'h00001);

    // counts oscillator cycles; restarts on every state change
    always_ff @(posedge I_CLK) begin
        if (I_SRST || state_next != state_reg)
            tmr_reg <= 17'h00000;
        else
            tmr_reg <= tmr_reg + 17'h00001; // R20
    end

    // ==========================================================
    // mode sequencer
    // trigger and wake-up errors take priority over mode changes so a bad trigger is never
    // masked by a simultaneous mode switch
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_POR: begin
                if (tmr_done) state_next = ST_SWCH; // R2
            end
            ST_SWCH: begin
                if (!mode_deb) state_next = ST_SDIS; // R3 R6
                else if (tmr_done) state_next = ST_RST; // R4
            end
            ST_RST: begin
                if (tmr_done) state_next = ST_SWCH; // R5 R26
            end
            ST_SDIS: begin
                if (trig_long || trig_rise) state_next = ST_RST; // R7 R8
                else if (mode_deb) state_next = ST_LDIS; // R13
                else if (tmr_done) state_next = ST_SEN; // R6
            end
            ST_SEN: begin
                if (trig_long) state_next = ST_RST; // R7
                else if (trig_rise) state_next = ST_SDIS; // R10
                else if (mode_deb) state_next = ST_LDIS; // R13
                else if (tmr_done) state_next = ST_RST; // R9
            end
            ST_LDIS: begin
                if (wake_evt || trig_long || trig_rise)
                    state_next = ST_RST; // R14 R16
                else if (!mode_deb) state_next = ST_SDIS; // R19
                else if (tmr_done) state_next = ST_LEN; // R14
            end
            ST_LEN: begin
                if (wake_evt || trig_long) state_next = ST_RST; // R16
                else if (trig_rise) state_next = ST_LDIS; // R14
                else if (!mode_deb) state_next = ST_SDIS; // R19
                else if (tmr_done) state_next = ST_RST; // R14
            end
            default: state_next = ST_POR;
        endcase
    end

    always_ff @(posedge I_CLK) begin
        if (I_SRST)
            state_reg <= ST_POR; // R1
        else
            state_reg <= state_next;
    end

    // ==========================================================
    // correct-trigger count and outputs
    logic [1:0] good_reg;
    logic [1:0] good_next;
    logic       short_next;

    always_comb begin
        good_next = good_reg;
        if (state_next == ST_RST || state_reg == ST_SWCH)
            good_next = 2'h0; // R12 R26
        else if (state_reg == ST_SEN && state_next == ST_SDIS
                 && good_reg != 2'h3)
            good_next = good_reg + 2'h1; // R11
    end
    assign short_next = (state_next == ST_SDIS) || (state_next == ST_SEN);

    always_ff @(posedge I_CLK) begin
        if (I_SRST) begin
            good_reg                <= 2'h0;
            O_PERIPHERAL_ENABLE_OUT <= 1'b0;
            O_RESET_OE              <= 1'b1; // R1
            O_RESET_OUT             <= 1'b0;
        end else begin
            good_reg <= good_next;
            // long mode keeps enable off, peripherals may power down
            O_PERIPHERAL_ENABLE_OUT <= short_next
                && good_next == 2'h3; // R11 R12 R15
            O_RESET_OE <= (state_next == ST_POR)
                || (state_next == ST_RST); // R2 R4 R16
            O_RESET_OUT <= 1'b0;
        end
    end

    // ==========================================================
    // checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    oe_state_a: assert property ( // R1
        O_RESET_OE == (state_reg == ST_POR || state_reg == ST_RST))
        else $error("reset output does not follow state");
    por_hold_a: assert property ( // R2
        $fell(O_RESET_OE) && $past(state_reg) == ST_POR
        |-> $past(tmr_reg) == P_T0 - 17'h00001)
        else $error("power-up reset length wrong");
    timeout_a: assert property ( // R4
        state_reg == ST_SWCH && tmr_done && mode_deb
        |=> state_reg == ST_RST && O_RESET_OE)
        else $error("no reset after switch-over timeout");
    pulse_back_a: assert property ( // R5
        state_reg == ST_RST && tmr_done |=> state_reg == ST_SWCH)
        else $error("reset pulse not followed by switch-over");
    early_trig_a: assert property ( // R8
        state_reg == ST_SDIS && trig_rise |=> state_reg == ST_RST)
        else $error("trigger in disable time not punished");
    no_trig_a: assert property ( // R9
        state_reg == ST_SEN && tmr_done && !trig_deb && !mode_deb
        |=> state_reg == ST_RST)
        else $error("missing trigger not punished");
    long_trig_a: assert property ( // R21
        (state_reg == ST_SDIS || state_reg == ST_SEN) && trig_long
        |=> O_RESET_OE)
        else $error("over-long trigger not punished");
    // the count survives a trip into long mode, so enable may also
    // come back on the way out of it
    en_three_a: assert property ( // R11
        $rose(O_PERIPHERAL_ENABLE_OUT) |-> good_reg == 2'h3
        && ($past(state_reg) == ST_SEN || $past(state_reg) == ST_LDIS
        || $past(state_reg) == ST_LEN))
        else $error("enable without three triggers");
    long_en_a: assert property ( // R15
        state_reg == ST_LDIS || state_reg == ST_LEN
        |-> !O_PERIPHERAL_ENABLE_OUT)
        else $error("enable active in long mode");
    wake_a: assert property ( // R16
        (state_reg == ST_LDIS || state_reg == ST_LEN) && wake_evt
        |=> O_RESET_OE ##[1:40] !O_RESET_OE)
        else $error("wake-up did not give one reset pulse");
    good_trig_a: assert property ( // R10
        state_reg == ST_SEN && trig_rise |=> state_reg == ST_SDIS)
        else $error("trigger in window did not restart cycle");
    to_long_a: assert property ( // R13
        (state_reg == ST_SDIS || state_reg == ST_SEN) && mode_deb
        && !trig_rise && !trig_long |=> state_reg == ST_LDIS)
        else $error("mode high did not select long window");
    to_short_a: assert property ( // R19
        (state_reg == ST_LDIS || state_reg == ST_LEN) && !mode_deb
        && !wake_evt && !trig_rise && !trig_long
        |=> state_reg == ST_SDIS)
        else $error("mode low did not select short window");
    long_win_a: assert property ( // R14
        state_reg == ST_LEN && trig_rise && !wake_evt
        |=> state_reg == ST_LDIS)
        else $error("long window trigger not accepted");
    long_hi_a: assert property ( // R18 R23
        state_reg == ST_LDIS && ts_lvl && mode_deb && !wake_evt
        && !trig_deb && tmr_reg == WWD_T4_HI - 17'h00001
        |=> state_reg == ST_LEN)
        else $error("long disable length wrong");
    swch_low_a: assert property ( // R6
        state_reg == ST_SWCH && !mode_deb
        |=> state_reg == ST_SDIS && !O_RESET_OE)
        else $error("switch-over did not enter short window");
    swch_wait_a: assert property ( // R26
        state_reg == ST_SWCH && mode_deb && !tmr_done
        |=> state_reg == ST_SWCH)
        else $error("switch-over left early");
    rst_quiet_a: assert property ( // R26
        state_reg == ST_RST && !tmr_done
        |=> state_reg == ST_RST && O_RESET_OE)
        else $error("reset pulse cut short");
    rst_clear_a: assert property ( // R12 R26
        state_reg == ST_POR || state_reg == ST_RST || state_reg == ST_SWCH
        |-> good_reg == 2'h0 && !O_PERIPHERAL_ENABLE_OUT)
        else $error("trigger count kept across reset");
    en_short_a: assert property ( // R11 R15
        O_PERIPHERAL_ENABLE_OUT |-> good_reg == 2'h3
        && (state_reg == ST_SDIS || state_reg == ST_SEN))
        else $error("enable outside three-trigger short mode");
    tmr_step_a: assert property ( // R20
        state_reg != ST_POR && $stable(state_reg)
        |-> tmr_reg == $past(tmr_reg) + 17'h00001)
        else $error("interval timer skipped a cycle");
    mode_deb_a: assert property ( // R25
        $changed(mode_deb) |-> $past(sync2_reg[WWD_B_MODE]) == mode_deb
        && $past(sync2_reg[WWD_B_MODE], 3) == mode_deb)
        else $error("mode level taken before debounce");
    trig_deb_a: assert property ( // R25
        $changed(trig_deb) |-> $past(sync2_reg[WWD_B_TRIG]) == trig_deb
        && $past(sync2_reg[WWD_B_TRIG], 3) == trig_deb)
        else $error("trigger level taken before debounce");

endmodule : wwd_top
`default_nettype wire
